// *** core/ssb_consts.svh ***
`ifndef SSB_CONSTS_SVH
`define SSB_CONSTS_SVH

// Register word indices; byte address is four times the index
`define SSB_IDX_VECTOR 10'h0F4
`define SSB_IDX_COMPARE 10'h0F5
`define SSB_IDX_MASK 10'h0F6
`define SSB_IDX_STATUS 10'h0F7
`define SSB_IDX_DATA 10'h0F8
`define SSB_IDX_PRIO 10'h0F9
`define SSB_IDX_CHAR 10'h0FA

// Event status bit positions
`define SSB_ST_OVR 7
`define SSB_ST_FRM 6
`define SSB_ST_PAR 5
`define SSB_ST_ADR 4
`define SSB_ST_BRK 3
`define SSB_ST_RXD 2
`define SSB_ST_TXB 1
`define SSB_ST_TXS 0

// Priority/control bit positions
`define SSB_PR_ADDR_MODE_ENABLE_BIT 7
`define SSB_PR_SB 6
`define SSB_PR_SA 5
`define SSB_PR_RXD 4
`define SSB_PR_TXD 3
`define SSB_PRL_NONE 3'h7

// Interrupt mask bit positions
`define SSB_MK_BSN 7
`define SSB_MK_RXEOB 6
`define SSB_MK_TXEOB 5
`define SSB_MK_RXE 4
`define SSB_MK_RXA 3
`define SSB_MK_RXB 2
`define SSB_MK_RXDI 1
`define SSB_MK_TXDI 0

// Character format bit positions
`define SSB_CH_AM 7
`define SSB_CH_EP 6
`define SSB_CH_PEN 5
`define SSB_CH_AB 4

// Reset values
`define SSB_RST_STATUS 8'h00
`define SSB_RST_MASK 8'h00
`define SSB_RST_PRIO 8'h07
`define SSB_RST_CHAR 8'h03
`define SSB_RST_COMPARE 8'h00
`define SSB_RST_VECTOR 5'h00

// Vector source codes
`define SSB_EV_ERR 2'h0
`define SSB_EV_BRKADR 2'h1
`define SSB_EV_RXD 2'h2
`define SSB_EV_TX 2'h3

// Start bit, five data bits and one stop bit
`define SSB_WORD_BASE 4'h7

`endif

// *** core/ssb_pkg.sv ***
package ssb_pkg;

    // One word handed over by the receive shifter at end of word
    typedef struct packed {
        logic all_low;
        logic stop_ok;
        logic par_bit;
        logic ninth;
        logic [7:0] data;
    } ssb_rx_word_t;

    // One byte handed to the transmit shifter
    typedef struct packed {
        logic addr;
        logic [7:0] data;
    } ssb_tx_load_t;

    // Service requests, highest rank first
    typedef struct packed {
        logic rx_dma;
        logic tx_dma;
        logic rx_int;
        logic tx_int;
    } ssb_svc_t;

    // Break generator states
    typedef enum logic [2:0] {
        SSB_BRK_IDLE = 3'b001,
        SSB_BRK_LOW = 3'b010,
        SSB_BRK_MARK = 3'b100
    } ssb_brk_state_t;

endpackage

// *** core/ssb_top.sv ***
`timescale 1ns/1ps
`include "ssb_consts.svh"
// Summary of operation
// [RL1] Overrun flag when unread data is overwritten
// [RL2] Framing flag on bad stop bit; still stored
// [RL3] Parity flag on wrong parity bit
// [RL4] Address flag on selected address-mode event
// [RL5] Break flag when line low whole word
// [RL6] Data flag whenever holding register is loaded
// [RL7] Buffer-empty flag when transmit holding empties
// [RL8] Shift-empty flag when shifter finished sending
// [RL9] Software may only clear flags, never set
// [RL10] Load at word end; pad unused bits high
// [RL11] Hand byte to free shifter; flag updates
// [RL12] Receive and transmit holding share one address
// [RL13] Four address-mode encodings of enable/select
// [RL14] Address word not stored; filter following words
// [RL15] Software clears address flag before next word
// [RL16] Break low at least one word, high end
// [RL17] Address bit sent then cleared by hardware
// [RL18] Software writes address bit before data byte
// [RL19] Receive DMA mask; cleared at count zero
// [RL20] Transmit DMA mask; cleared at count zero
// [RL21] Three-bit priority, seven means none
// [RL22] Rank: rx DMA, tx DMA, rx int, tx int
// [RL23] Two-bit vector code names interrupt source
// [RL24] Write zero clears; hardware set wins
module ssb_top
    import ssb_pkg::*;
(
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic RX_WORD_DONE,
    input wire ssb_rx_word_t RX_WORD,
    input wire logic TX_SHIFT_FREE,
    input wire logic TX_SHIFT_DONE,
    input wire logic TX_BIT_TICK,
    output logic TX_LOAD,
    output ssb_tx_load_t TX_LOAD_WORD,
    output logic TX_BREAK_LOW,
    input wire logic RX_DMA_TC_ZERO,
    input wire logic TX_DMA_TC_ZERO,
    output ssb_svc_t SVC_GRANT,
    output logic [2:0] SVC_LEVEL
);

    // True when the address is aligned and selects word idx
    function automatic logic reg_hit(input logic [11:0] addr, input logic [9:0] idx);
        reg_hit = (addr[1:0] == 2'h0) && (addr[11:2] == idx);
    endfunction

    // Bits that belong to the selected word length
    function automatic logic [7:0] wl_mask(input logic [1:0] wl);
        wl_mask = 8'hFF >> (2'h3 - wl);
    endfunction

    // Fixed in-block ranking: one request wins
    function automatic ssb_svc_t rank(input ssb_svc_t req);
        rank = '0;
        if (req.rx_dma) begin
            rank.rx_dma = 1'b1;
        end else if (req.tx_dma) begin
            rank.tx_dma = 1'b1;
        end else if (req.rx_int) begin
            rank.rx_int = 1'b1;
        end else if (req.tx_int) begin
            rank.tx_int = 1'b1;
        end
    endfunction

    logic [7:0] status_r; // Event flags
    logic [7:0] mask_r; // Interrupt enables and end-of-block flags
    logic [7:0] prio_r; // Address mode, break, address bit, DMA masks, level
    logic [7:0] char_r; // Character format
    logic [7:0] compare_r; // Address / search character
    logic [4:0] vec_r; // Writable vector base
    logic [7:0] rhr_r; // Receive holding register
    logic [7:0] thr_r; // Transmit holding register
    logic thr_full_r; // Transmit holding holds an unsent byte
    logic unread_r; // Receive holding not yet read
    logic matched_r; // Last address word matched
    logic after_brk_r; // Next word follows a break
    logic ack_r; // APB wait-state toggle
    logic [31:0] prdata_r; // Registered read data
    logic [3:0] brk_cnt_r; // Transmit bit periods spent in break
    ssb_brk_state_t brk_state_r; // Break generator state
    ssb_tx_load_t tx_word_r; // Word last handed to the shifter

    // APB decode
    logic access;
    logic valid;
    logic wr_done;
    logic rd_data_done;
    logic wr_status;
    logic wr_data;
    logic wr_prio;
    logic wr_mask;
    logic [31:0] rd_val;

    assign access = PSEL && PENABLE;
    assign valid = reg_hit(PADDR, `SSB_IDX_VECTOR) || reg_hit(PADDR, `SSB_IDX_COMPARE)
        || reg_hit(PADDR, `SSB_IDX_MASK) || reg_hit(PADDR, `SSB_IDX_STATUS)
        || reg_hit(PADDR, `SSB_IDX_DATA) || reg_hit(PADDR, `SSB_IDX_PRIO)
        || reg_hit(PADDR, `SSB_IDX_CHAR);
    // One wait state so that read data comes from a flip-flop
    assign PREADY = access && ack_r;
    assign PSLVERR = PREADY && !valid;
    assign PRDATA = prdata_r;
    assign wr_done = PREADY && PWRITE && valid;
    assign wr_status = wr_done && reg_hit(PADDR, `SSB_IDX_STATUS);
    assign wr_data = wr_done && reg_hit(PADDR, `SSB_IDX_DATA);
    assign wr_prio = wr_done && reg_hit(PADDR, `SSB_IDX_PRIO);
    assign wr_mask = wr_done && reg_hit(PADDR, `SSB_IDX_MASK);
    assign rd_data_done = PREADY && !PWRITE && reg_hit(PADDR, `SSB_IDX_DATA);

    // Format fields
    logic addr_mode_enable_bit;
    logic am;
    logic ab;
    logic pen;
    logic [7:0] wmask;
    logic [3:0] word_bits;

    assign addr_mode_enable_bit = prio_r[`SSB_PR_ADDR_MODE_ENABLE_BIT];
    assign am = char_r[`SSB_CH_AM];
    assign ab = char_r[`SSB_CH_AB];
    assign pen = char_r[`SSB_CH_PEN];
    assign wmask = wl_mask(char_r[1:0]);
    assign word_bits = `SSB_WORD_BASE + {2'h0, char_r[1:0]} + {3'h0, pen} + {3'h0, ab};

    // Receive word classification
    logic rx_brk;
    logic rx_word;
    logic match;
    logic is_addr;
    logic addr_evt;
    logic store;
    logic par_err;
    logic [7:0] rx_fill;

    always_comb begin
        rx_brk = RX_WORD_DONE && RX_WORD.all_low;
        rx_word = RX_WORD_DONE && !RX_WORD.all_low;
        match = (RX_WORD.data & wmask) == (compare_r & wmask);
        // Even parity: all bits xor to zero; odd: to one
        par_err = pen && ((^(RX_WORD.data & wmask) ^ RX_WORD.par_bit) == char_r[`SSB_CH_EP]); // RL3
        rx_fill = RX_WORD.data | ~wmask; // RL10
        is_addr = 1'b0;
        addr_evt = 1'b0;
        case ({addr_mode_enable_bit, am}) // RL13
            2'b00: begin
                addr_evt = ab && RX_WORD.ninth;
            end
            2'b01: begin
                addr_evt = match; // Character search, word still stored
            end
            2'b10: begin
                is_addr = ab && RX_WORD.ninth;
                addr_evt = is_addr && match;
            end
            2'b11: begin
                is_addr = after_brk_r;
                addr_evt = is_addr && match;
            end
            default: begin
                addr_evt = 1'b0;
            end
        endcase
        // Address words are dropped; data only after a match, but a
        // framing error while hunting still reaches the buffer
        store = rx_word && (!addr_mode_enable_bit || (!is_addr && matched_r) || !RX_WORD.stop_ok); // RL14 RL2
    end

    // Address filter state
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            matched_r <= 1'b0;
            after_brk_r <= 1'b0;
        end else begin
            if (rx_brk) begin
                after_brk_r <= 1'b1;
            end else if (rx_word) begin
                after_brk_r <= 1'b0;
            end
            if (rx_word && addr_mode_enable_bit && is_addr) begin
                matched_r <= match; // RL14
            end
        end
    end

    // Receive holding register and unread tracking
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rhr_r <= 8'h00;
            unread_r <= 1'b0;
        end else begin
            if (store) begin
                rhr_r <= rx_fill; // RL10
            end
            // A new load wins over a read in the same cycle
            if (store) begin
                unread_r <= 1'b1;
            end else if (rd_data_done) begin
                unread_r <= 1'b0;
            end
        end
    end

    // Transmit side: holding register to shifter
    logic brk_idle;
    assign brk_idle = (brk_state_r == SSB_BRK_IDLE);
    assign TX_LOAD = thr_full_r && TX_SHIFT_FREE && brk_idle; // RL11
    assign TX_LOAD_WORD = tx_word_r;

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            thr_r <= 8'h00;
            thr_full_r <= 1'b0;
            tx_word_r <= '0;
        end else begin
            if (wr_data) begin
                thr_r <= PWDATA[7:0]; // RL12
            end
            if (wr_data) begin
                thr_full_r <= 1'b1;
            end else if (TX_LOAD) begin
                thr_full_r <= 1'b0;
            end
            if (TX_LOAD) begin
                // Upper bits beyond the word length are cleared to zero
                tx_word_r.data <= thr_r & wmask; // RL11
                tx_word_r.addr <= ab && prio_r[`SSB_PR_SA]; // RL17
            end
        end
    end

    // Event flag set sources
    logic [7:0] st_set;
    logic [7:0] st_clr;
    always_comb begin
        st_set = 8'h00;
        st_set[`SSB_ST_OVR] = store && unread_r; // RL1
        st_set[`SSB_ST_FRM] = rx_word && !RX_WORD.stop_ok; // RL2
        st_set[`SSB_ST_PAR] = rx_word && par_err; // RL3
        st_set[`SSB_ST_ADR] = rx_word && addr_evt; // RL4
        st_set[`SSB_ST_BRK] = rx_brk; // RL5
        st_set[`SSB_ST_RXD] = store; // RL6
        st_set[`SSB_ST_TXB] = TX_LOAD; // RL7
        st_set[`SSB_ST_TXS] = TX_SHIFT_DONE; // RL8
        // Software can only clear, by writing zero
        st_clr = wr_status ? ~PWDATA[7:0] : 8'h00; // RL9 RL24
        // DMA service of the data register retires its own flag
        st_clr[`SSB_ST_RXD] = st_clr[`SSB_ST_RXD] || (rd_data_done && prio_r[`SSB_PR_RXD]);
        st_clr[`SSB_ST_TXB] = st_clr[`SSB_ST_TXB] || (wr_data && prio_r[`SSB_PR_TXD]);
        st_clr[`SSB_ST_TXS] = st_clr[`SSB_ST_TXS] || (wr_data && prio_r[`SSB_PR_TXD]);
    end

    // One flop per flag; a set in the clear cycle survives
    localparam logic [7:0] st_reset = `SSB_RST_STATUS; // Reset image of the event flags
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_flag
            always_ff @(posedge CLK or negedge RESET_N) begin
                if (!RESET_N) begin
                    status_r[gi] <= st_reset[gi];
                end else begin
                    status_r[gi] <= st_set[gi] || (status_r[gi] && !st_clr[gi]); // RL24
                end
            end
        end
    endgenerate

    // Priority / control register
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            prio_r <= `SSB_RST_PRIO;
        end else if (wr_prio) begin
            prio_r <= PWDATA[7:0]; // Software write wins a same-cycle clear
        end else begin
            if (RX_DMA_TC_ZERO) begin
                prio_r[`SSB_PR_RXD] <= 1'b0; // RL19
            end
            if (TX_DMA_TC_ZERO) begin
                prio_r[`SSB_PR_TXD] <= 1'b0; // RL20
            end
            if (TX_LOAD && ab) begin
                prio_r[`SSB_PR_SA] <= 1'b0; // RL17
            end
        end
    end

    // Interrupt mask; end-of-block bits are set by hardware only
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            mask_r <= `SSB_RST_MASK;
        end else begin
            if (wr_mask) begin
                mask_r <= {PWDATA[7], mask_r[6:5] & PWDATA[6:5], PWDATA[4:0]};
            end
            if (RX_DMA_TC_ZERO) begin
                mask_r[`SSB_MK_RXEOB] <= 1'b1; // RL19
            end
            if (TX_DMA_TC_ZERO) begin
                mask_r[`SSB_MK_TXEOB] <= 1'b1; // RL20
            end
        end
    end

    // Plain configuration registers
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            char_r <= `SSB_RST_CHAR;
            compare_r <= `SSB_RST_COMPARE;
            vec_r <= `SSB_RST_VECTOR;
        end else begin
            if (wr_done && reg_hit(PADDR, `SSB_IDX_CHAR)) begin
                char_r <= PWDATA[7:0];
            end
            if (wr_done && reg_hit(PADDR, `SSB_IDX_COMPARE)) begin
                compare_r <= PWDATA[7:0];
            end
            if (wr_done && reg_hit(PADDR, `SSB_IDX_VECTOR)) begin
                vec_r <= PWDATA[7:3];
            end
        end
    end

    // Break generator
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            brk_state_r <= SSB_BRK_IDLE;
            brk_cnt_r <= 4'h0;
        end else begin
            case (brk_state_r)
                SSB_BRK_IDLE: begin
                    // Wait until both holding and shift registers are empty
                    if (prio_r[`SSB_PR_SB] && !thr_full_r && TX_SHIFT_FREE) begin
                        brk_state_r <= SSB_BRK_LOW; // RL16
                        brk_cnt_r <= 4'h0;
                    end
                end
                SSB_BRK_LOW: begin
                    if (TX_BIT_TICK && (brk_cnt_r < word_bits)) begin
                        brk_cnt_r <= brk_cnt_r + 4'h1;
                    end
                    if ((brk_cnt_r >= word_bits) && !prio_r[`SSB_PR_SB]) begin
                        brk_state_r <= SSB_BRK_MARK; // RL16
                    end
                end
                SSB_BRK_MARK: begin
                    // One transmit period of mark closes the break
                    if (TX_BIT_TICK) begin
                        brk_state_r <= SSB_BRK_IDLE; // RL16
                    end
                end
                default: begin
                    brk_state_r <= SSB_BRK_IDLE;
                end
            endcase
        end
    end
    assign TX_BREAK_LOW = (brk_state_r == SSB_BRK_LOW);

    // Interrupt sources, DMA requests and vector code
    logic err_int;
    logic ba_int;
    logic rxd_int;
    logic tx_src;
    logic tx_int;
    logic [1:0] ev;
    ssb_svc_t req;
    always_comb begin
        err_int = |status_r[`SSB_ST_OVR:`SSB_ST_PAR] && mask_r[`SSB_MK_RXE];
        ba_int = (status_r[`SSB_ST_ADR] && mask_r[`SSB_MK_RXA])
            || (status_r[`SSB_ST_BRK] && mask_r[`SSB_MK_RXB]);
        rxd_int = mask_r[`SSB_MK_RXDI] && ((status_r[`SSB_ST_RXD] && !prio_r[`SSB_PR_RXD])
            || mask_r[`SSB_MK_RXEOB]); // RL19
        tx_src = mask_r[`SSB_MK_BSN] ? status_r[`SSB_ST_TXB] : status_r[`SSB_ST_TXS];
        tx_int = mask_r[`SSB_MK_TXDI] && ((tx_src && !prio_r[`SSB_PR_TXD])
            || mask_r[`SSB_MK_TXEOB]); // RL20
        if (err_int) begin
            ev = `SSB_EV_ERR; // RL23
        end else if (ba_int) begin
            ev = `SSB_EV_BRKADR;
        end else if (rxd_int) begin
            ev = `SSB_EV_RXD;
        end else begin
            ev = `SSB_EV_TX;
        end
        req.rx_dma = prio_r[`SSB_PR_RXD] && status_r[`SSB_ST_RXD]; // RL19
        req.tx_dma = prio_r[`SSB_PR_TXD] && tx_src; // RL20
        req.rx_int = err_int || ba_int || rxd_int;
        req.tx_int = tx_int;
    end

    // Level seven silences every request
    assign SVC_LEVEL = prio_r[2:0]; // RL21
    assign SVC_GRANT = (prio_r[2:0] == `SSB_PRL_NONE) ? ssb_svc_t'('0) : rank(req); // RL21 RL22

    // Read mux; the data index reads the receive side only
    always_comb begin
        rd_val = 32'h0000_0000;
        if (reg_hit(PADDR, `SSB_IDX_STATUS)) begin
            rd_val[7:0] = status_r;
        end else if (reg_hit(PADDR, `SSB_IDX_DATA)) begin
            rd_val[7:0] = rhr_r; // RL12
        end else if (reg_hit(PADDR, `SSB_IDX_PRIO)) begin
            rd_val[7:0] = prio_r;
        end else if (reg_hit(PADDR, `SSB_IDX_MASK)) begin
            rd_val[7:0] = mask_r;
        end else if (reg_hit(PADDR, `SSB_IDX_CHAR)) begin
            rd_val[7:0] = char_r;
        end else if (reg_hit(PADDR, `SSB_IDX_COMPARE)) begin
            rd_val[7:0] = compare_r;
        end else if (reg_hit(PADDR, `SSB_IDX_VECTOR)) begin
            rd_val[7:0] = {vec_r, ev, 1'b0}; // RL23
        end
    end

    // APB answer timing and read capture
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ack_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            ack_r <= access && !ack_r;
            if (access && !ack_r && !PWRITE) begin
                prdata_r <= rd_val;
            end
        end
    end

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESET_N);

    a_overrun_set: assert property (store && unread_r |=> status_r[`SSB_ST_OVR]) // RL1
        else $error("overrun not flagged");
    a_framing_store: assert property (rx_word && !RX_WORD.stop_ok |=> status_r[`SSB_ST_FRM] && status_r[`SSB_ST_RXD]) // RL2
        else $error("framing word not flagged or stored");
    a_parity_set: assert property (rx_word && par_err |=> status_r[`SSB_ST_PAR]) // RL3
        else $error("parity error not flagged");
    a_addr_pending: assert property (rx_word && addr_evt |=> status_r[`SSB_ST_ADR]) // RL4
        else $error("address event not flagged");
    a_break_flag: assert property (rx_brk |=> status_r[`SSB_ST_BRK] && !$changed(rhr_r)) // RL5
        else $error("break not flagged or stored");
    a_rx_load: assert property (store |=> status_r[`SSB_ST_RXD] && rhr_r == $past(rx_fill)) // RL6 RL10
        else $error("receive load wrong");
    a_txbuf_empty: assert property (TX_LOAD |=> status_r[`SSB_ST_TXB] && (!thr_full_r || $past(wr_data))) // RL7 RL11
        else $error("buffer empty not flagged");
    a_shift_empty: assert property (TX_SHIFT_DONE |=> status_r[`SSB_ST_TXS]) // RL8
        else $error("shift empty not flagged");
    a_clear_only: assert property (wr_status && st_set == 8'h00 |=> (status_r & ~$past(status_r)) == 8'h00) // RL9
        else $error("software set a flag");
    a_set_wins: assert property (wr_status && st_set[`SSB_ST_RXD] |=> status_r[`SSB_ST_RXD]) // RL24
        else $error("clear beat hardware set");
    a_addr_drop: assert property (rx_word && addr_mode_enable_bit && is_addr && RX_WORD.stop_ok |-> !store) // RL14
        else $error("address word stored");
    a_break_length: assert property ($fell(TX_BREAK_LOW) |-> $past(brk_cnt_r) >= $past(word_bits)) // RL16
        else $error("break too short");
    a_sa_clear: assert property (TX_LOAD && ab && !wr_prio |=> !prio_r[`SSB_PR_SA]) // RL17
        else $error("address bit not cleared");
    a_dma_mask_end: assert property (RX_DMA_TC_ZERO && !wr_prio && !wr_mask
        |=> !prio_r[`SSB_PR_RXD] && mask_r[`SSB_MK_RXEOB]) // RL19
        else $error("receive DMA end not handled");
    a_prio_none: assert property (SVC_LEVEL == `SSB_PRL_NONE |-> SVC_GRANT == ssb_svc_t'('0)) // RL21
        else $error("grant at level seven");
    a_rank_order: assert property (req.rx_dma && SVC_LEVEL != `SSB_PRL_NONE |-> SVC_GRANT == 4'b1000) // RL22
        else $error("receive DMA not ranked first");
    a_vector_code: assert property (err_int |-> ev == `SSB_EV_ERR) // RL23
        else $error("vector code wrong");

    c_rx_overrun: cover property (store && unread_r);
    c_break_sent: cover property ($fell(TX_BREAK_LOW));
    c_addr_match: cover property (rx_word && addr_mode_enable_bit && is_addr && match);
    c_dma_end: cover property (TX_DMA_TC_ZERO);

endmodule

// *** sim/ssb_peer.sv ***
`timescale 1ns/1ps
// Far-side serial peer: supplies received words and paces the shifter
module ssb_peer
    import ssb_pkg::*;
(
    input wire logic clk,
    input wire logic tx_load,
    output logic rx_done,
    output ssb_rx_word_t rx_word,
    output logic shift_free,
    output logic shift_done,
    output logic bit_tick
);
    logic [1:0] busy_cnt; // Shift time left

    initial begin
        rx_done = 1'b0;
        rx_word = '0;
        shift_free = 1'b1;
        shift_done = 1'b0;
        bit_tick = 1'b0;
        busy_cnt = 2'h0;
    end

    // Shifter stays busy three cycles per byte, then reports done
    always @(posedge clk) begin
        bit_tick <= ~bit_tick;
        shift_done <= (busy_cnt == 2'h1);
        shift_free <= !tx_load && busy_cnt <= 2'h1;
        if (tx_load) begin
            busy_cnt <= 2'h3;
        end else if (busy_cnt != 2'h0) begin
            busy_cnt <= busy_cnt - 2'h1;
        end
    end

    // One word per call; afterwards the bus shows junk, not the old word
    task automatic send(input logic [7:0] d, input logic ok, input logic brk);
        @(posedge clk);
        rx_done <= 1'b1;
        rx_word <= {brk, ok, 1'b0, 1'b0, d};
        @(posedge clk);
        rx_done <= 1'b0;
        rx_word <= ~rx_word;
    endtask
endmodule

// *** sim/testbench.sv ***
`timescale 1ns/1ps
// Register-level bench: APB calls with expected values
module testbench
    import ssb_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic rx_tc = 1'b0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, rx_done, s_free, s_done, tick, tx_load, brk_low;
    ssb_rx_word_t rx_word;
    ssb_tx_load_t tx_word;
    ssb_svc_t grant;
    logic [2:0] level;
    int error_cnt = 0;
    int samples_checked = 0;
    int cycles = 0;

    always #5 clk = ~clk;

    ssb_top u_dut (.CLK(clk), .RESET_N(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .RX_WORD_DONE(rx_done),
        .RX_WORD(rx_word), .TX_SHIFT_FREE(s_free), .TX_SHIFT_DONE(s_done), .TX_BIT_TICK(tick),
        .TX_LOAD(tx_load), .TX_LOAD_WORD(tx_word), .TX_BREAK_LOW(brk_low), .RX_DMA_TC_ZERO(rx_tc),
        .TX_DMA_TC_ZERO(1'b0), .SVC_GRANT(grant), .SVC_LEVEL(level));

    ssb_peer u_peer (.clk(clk), .tx_load(tx_load), .rx_done(rx_done), .rx_word(rx_word),
        .shift_free(s_free), .shift_done(s_done), .bit_tick(tick));

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask

    // APB transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    task automatic rdchk(input string n, input logic [9:0] idx, input logic [7:0] e);
        apb(1'b0, idx, 8'h00);
        chk(n, {24'h0, e}, rd);
    endtask

    // Hang guard; the run needs a few hundred cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            error_cnt++;
            print_verdict;
        end
    end

    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rdchk("status", 10'h0F7, 8'h00);
        rdchk("prio", 10'h0F9, 8'h07);
        u_peer.send(8'h5A, 1'b1, 1'b0);
        rdchk("status", 10'h0F7, 8'h04);
        rdchk("rx data", 10'h0F8, 8'h5A);
        u_peer.send(8'h11, 1'b1, 1'b0);
        u_peer.send(8'h22, 1'b1, 1'b0);
        rdchk("status", 10'h0F7, 8'h84);
        rdchk("rx data", 10'h0F8, 8'h22);
        apb(1'b1, 10'h0F6, 8'h10);
        rdchk("vector", 10'h0F4, 8'h00);
        apb(1'b1, 10'h0F7, 8'h7F);
        rdchk("status", 10'h0F7, 8'h04);
        apb(1'b1, 10'h0F7, 8'hFF);
        rdchk("status", 10'h0F7, 8'h04);
        u_peer.send(8'h0F, 1'b0, 1'b0);
        u_peer.send(8'h00, 1'b1, 1'b1);
        rdchk("status", 10'h0F7, 8'h4C);
        apb(1'b1, 10'h0F7, 8'h00);
        apb(1'b1, 10'h0FA, 8'h13);
        apb(1'b1, 10'h0F9, 8'h27);
        apb(1'b1, 10'h0F8, 8'h33);
        while (tx_load !== 1'b1) @(posedge clk);
        @(posedge clk);
        chk("tx byte", 32'h133, {23'h0, tx_word});
        while (s_done !== 1'b1) @(posedge clk);
        rdchk("status", 10'h0F7, 8'h03);
        rdchk("prio", 10'h0F9, 8'h07);
        apb(1'b1, 10'h0F9, 8'h12);
        u_peer.send(8'h77, 1'b1, 1'b0);
        @(posedge clk);
        chk("grant", 32'h8, {28'h0, grant});
        chk("level", 32'h2, {29'h0, level});
        rx_tc <= 1'b1;
        @(posedge clk);
        rx_tc <= 1'b0;
        rdchk("prio", 10'h0F9, 8'h02);
        apb(1'b1, 10'h0F9, 8'h42);
        while (brk_low !== 1'b1) @(posedge clk);
        apb(1'b1, 10'h0F9, 8'h02);
        chk("break held", 32'h1, {31'h0, brk_low});
        repeat (40) @(posedge clk);
        chk("break end", 32'h0, {31'h0, brk_low});
        apb(1'b1, 10'h0F5, 8'h41);
        apb(1'b1, 10'h0FA, 8'h93);
        apb(1'b1, 10'h0F9, 8'h82);
        apb(1'b1, 10'h0F7, 8'h00);
        u_peer.send(8'h00, 1'b1, 1'b1);
        u_peer.send(8'h41, 1'b1, 1'b0);
        rdchk("status", 10'h0F7, 8'h18);
        apb(1'b1, 10'h0F7, 8'hEF);
        u_peer.send(8'h55, 1'b1, 1'b0);
        rdchk("rx data", 10'h0F8, 8'h55);
        rdchk("status", 10'h0F7, 8'h8C);
        u_peer.send(8'h00, 1'b1, 1'b1);
        u_peer.send(8'h42, 1'b1, 1'b0);
        u_peer.send(8'h66, 1'b1, 1'b0);
        rdchk("rx data", 10'h0F8, 8'h55);
        apb(1'b0, 10'h100, 8'h00);
        chk("slave error", 32'h1, {31'h0, err});
        print_verdict;
    end
endmodule
